/* design/mpt_pkg.sv */
// constants, field layout and enumerations of the multi purpose timer
// assumes one 20 MHz core clock and an 8-bit register port with one-cycle read latency
// Operation
// - free-running up-counter is compared with comparators; equality is a match
// - a match raises an interrupt, may clear the counter and alter the pin
// - separate interrupt requests for comparator A and comparator P matches
// - three-bit clock select picks system ratio, high clock, sub clock or pin
// - with the pin selected, the counter advances on pin edges
// - active edge of the clock pin is rising or falling
// - standard and periodic variants reuse the clock pin as single pulse trigger
// - compare output mode drives the pin high, low or toggles on a match
// - the same output pin carries the pwm waveform in pwm mode
// - high bytes accessed directly, low bytes only through one 8-bit shadow buffer
// - shadow and low byte exchange data only on a high-byte access
// - a compare low-byte write only updates the shadow buffer
// - a compare high-byte write loads high byte and shadow into low byte together
// - a high-byte read returns high byte and captures low byte into shadow
// - a low-byte read returns the shadow buffer, not the live low byte
// - compact variant has 16-bit counter, compare, counter and pwm modes, no pulse mode
// - comparator P matches upper eight counter bits, comparator A all sixteen
// - software clears the counter by raising run; overflow and a match of the selected comparator (A or P) clear it too
package mpt_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 16;
   // register offsets
   localparam logic [2:0] REG_CTL0 = 3'h0;
   localparam logic [2:0] REG_CTL1 = 3'h1;
   localparam logic [2:0] REG_CNT_L = 3'h2;
   localparam logic [2:0] REG_CNT_H = 3'h3;
   localparam logic [2:0] REG_CMPA_L = 3'h4;
   localparam logic [2:0] REG_CMPA_H = 3'h5;
   localparam logic [2:0] REG_CMPP = 3'h6;
   // timer_control_zero fields
   localparam int unsigned C0_PAUSE = 7;
   localparam int unsigned C0_SEL_HI = 6;
   localparam int unsigned C0_SEL_LO = 4;
   localparam int unsigned C0_RUN = 3;
   // second control register fields
   localparam int unsigned C1_MODE_HI = 7;
   localparam int unsigned C1_MODE_LO = 6;
   localparam int unsigned C1_IO_HI = 5;
   localparam int unsigned C1_IO_LO = 4;
   localparam int unsigned C1_OC = 3;
   localparam int unsigned C1_POL = 2;
   localparam int unsigned C1_DPX = 1;
   localparam int unsigned C1_CCLR = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // counter_clock_select codes
   localparam logic [2:0] SEL_SYS_DIV4 = 3'h0;
   localparam logic [2:0] SEL_SYS = 3'h1;
   localparam logic [2:0] SEL_FH_DIV16 = 3'h2;
   localparam logic [2:0] SEL_FH_DIV64 = 3'h3;
   localparam logic [2:0] SEL_SUB_A = 3'h4;
   localparam logic [2:0] SEL_SUB_B = 3'h5;
   localparam logic [2:0] SEL_PIN_RISE = 3'h6;
   localparam logic [2:0] SEL_PIN_FALL = 3'h7;
   localparam logic [1:0] SYS_DIV_LAST = 2'h3;
   localparam logic [5:0] FH16_LAST = 6'h0f;
   localparam logic [5:0] FH64_LAST = 6'h3f;
   // operating modes and pin actions
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;
   localparam logic [1:0] IO_HOLD = 2'h0;
   localparam logic [1:0] IO_LOW = 2'h1;
   localparam logic [1:0] IO_HIGH = 2'h2;
   localparam logic [1:0] IO_TOGGLE = 2'h3;
   localparam logic [1:0] PWM_INACTIVE = 2'h0;
   localparam logic [1:0] PWM_ACTIVE = 2'h1;
   localparam logic [1:0] PWM_WAVE = 2'h2;
endpackage

/* design/mpt_clk_src.sv */
// counter clock source: prescalers and clock pin edge detect, one tick pulse out
// assumes fh_tick_i and fsub_tick_i are one-cycle enables and the pin is synchronous
`timescale 1ns/1ps
module mpt_clk_src (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [2:0] sel_i,
   input wire logic fh_tick_i,
   input wire logic fsub_tick_i,
   input wire logic clock_pin_i,
   output logic tick_o
);
   import mpt_pkg::*;
   logic [1:0] sys_div, next_sys_div;
   logic [5:0] fh_div, next_fh_div;
   logic pin_prev, next_pin_prev;
   logic next_tick;

   // prescalers, edge detect and source selection
   always_comb begin
      next_sys_div = sys_div + 2'h1;
      next_fh_div = fh_tick_i ? fh_div + 6'h01 : fh_div;
      next_pin_prev = clock_pin_i;
      case (sel_i)
         SEL_SYS_DIV4: next_tick = (sys_div == SYS_DIV_LAST);
         SEL_SYS: next_tick = 1'b1;
         SEL_FH_DIV16: next_tick = fh_tick_i && (fh_div[3:0] == FH16_LAST[3:0]);
         SEL_FH_DIV64: next_tick = fh_tick_i && (fh_div == FH64_LAST);
         SEL_SUB_A, SEL_SUB_B: next_tick = fsub_tick_i;
         // pin edges count external events; trigger use belongs to the larger variants
         SEL_PIN_RISE: next_tick = clock_pin_i && !pin_prev;
         SEL_PIN_FALL: next_tick = !clock_pin_i && pin_prev;
         default: next_tick = 1'b0;
      endcase
   end

   // registers
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sys_div <= 2'h0;
         fh_div <= 6'h00;
         pin_prev <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         sys_div <= next_sys_div;
         fh_div <= next_fh_div;
         pin_prev <= next_pin_prev;
         tick_o <= next_tick;
      end
   end
endmodule

/* design/mpt_timer.sv */
// compact multi purpose timer: 16-bit counter, comparators A and P, output pin, byte port
// assumes a register master that never strobes read and write together
`timescale 1ns/1ps
module mpt_timer (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [mpt_pkg::ADDR_W-1:0] addr_i,
   input wire logic [mpt_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [mpt_pkg::DATA_W-1:0] rdata_o,
   input wire logic fh_tick_i,
   input wire logic fsub_tick_i,
   input wire logic clock_pin_i,
   output logic out_pin_o,
   output logic irq_a_o,
   output logic irq_p_o
);
   import mpt_pkg::*;

   logic [7:0] ctl0, next_ctl0;
   logic [7:0] ctl1, next_ctl1;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [CNT_W-1:0] cmpa, next_cmpa;
   logic [7:0] cmpp, next_cmpp;
   logic [7:0] shadow, next_shadow;
   logic [7:0] next_rdata;
   logic out_lvl, next_out_lvl;
   logic next_out_pin;
   logic next_irq_a, next_irq_p;
   logic tick;
   logic run_rise;
   logic count_en;
   logic [CNT_W-1:0] inc;
   logic match_a, match_p;
   logic clear_on_a;
   logic [1:0] mode, io;

   // P compares only the upper counter byte, on entering that byte
   function automatic logic hit_p(input logic [CNT_W-1:0] v, input logic [7:0] p);
      hit_p = (v[CNT_W-1:CNT_W-8] == p) && (v[7:0] == 8'h00);
   endfunction

   // pwm level from the active flag and the active-level bit
   function automatic logic pwm_level(input logic active, input logic oc);
      pwm_level = active ? oc : !oc;
   endfunction

   mpt_clk_src u_clk_src (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .sel_i(ctl0[C0_SEL_HI:C0_SEL_LO]),
      .fh_tick_i(fh_tick_i),
      .fsub_tick_i(fsub_tick_i),
      .clock_pin_i(clock_pin_i),
      .tick_o(tick)
   );

   assign mode = ctl1[C1_MODE_HI:C1_MODE_LO];
   assign io = ctl1[C1_IO_HI:C1_IO_LO];
   assign run_rise = wr_i && (addr_i == REG_CTL0) && wdata_i[C0_RUN] && !ctl0[C0_RUN];
   assign count_en = tick && ctl0[C0_RUN] && !ctl0[C0_PAUSE];

   // register port: control writes and the shared low-byte shadow
   always_comb begin
      next_ctl0 = ctl0;
      next_ctl1 = ctl1;
      next_cmpa = cmpa;
      next_cmpp = cmpp;
      next_shadow = shadow;
      next_rdata = 8'h00;
      if (wr_i) begin
         case (addr_i)
            REG_CTL0: next_ctl0 = {wdata_i[7:3], 3'h0};
            REG_CTL1: next_ctl1 = wdata_i;
            REG_CMPA_L: next_shadow = wdata_i;
            REG_CMPA_H: next_cmpa = {wdata_i, shadow};
            REG_CMPP: next_cmpp = wdata_i;
            default: next_cmpp = cmpp;
         endcase
      end else if (rd_i) begin
         case (addr_i)
            REG_CTL0: next_rdata = ctl0;
            REG_CTL1: next_rdata = ctl1;
            REG_CNT_L, REG_CMPA_L: next_rdata = shadow;
            REG_CNT_H: begin
               next_rdata = cnt[15:8];
               next_shadow = cnt[7:0];
            end
            REG_CMPA_H: begin
               next_rdata = cmpa[15:8];
               next_shadow = cmpa[7:0];
            end
            REG_CMPP: next_rdata = cmpp;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // counter, compare matches and automatic clearing
   always_comb begin
      inc = cnt + 16'h0001; // wraps to zero on overflow
      match_a = count_en && (inc == cmpa);
      match_p = count_en && hit_p(inc, cmpp);
      if (mode == MODE_PWM) begin
         clear_on_a = ctl1[C1_DPX];
      end else begin
         clear_on_a = ctl1[C1_CCLR];
      end
      next_cnt = cnt;
      if (run_rise) begin
         next_cnt = 16'h0000;
      end else if (count_en) begin
         if ((clear_on_a && match_a) || (!clear_on_a && match_p)) begin
            next_cnt = 16'h0000;
         end else begin
            next_cnt = inc;
         end
      end
      next_irq_a = match_a;
      next_irq_p = match_p;
   end

   // output pin: compare actions, pwm waveform, polarity
   always_comb begin
      next_out_lvl = out_lvl;
      case (mode)
         MODE_CMP: begin
            if (run_rise) begin
               next_out_lvl = ctl1[C1_OC];
            end else if (match_a) begin
               case (io)
                  IO_LOW: next_out_lvl = 1'b0;
                  IO_HIGH: next_out_lvl = 1'b1;
                  IO_TOGGLE: next_out_lvl = !out_lvl;
                  default: next_out_lvl = out_lvl;
               endcase
            end
         end
         MODE_PWM: begin
            case (io)
               PWM_INACTIVE: next_out_lvl = pwm_level(1'b0, ctl1[C1_OC]);
               PWM_ACTIVE: next_out_lvl = pwm_level(1'b1, ctl1[C1_OC]);
               PWM_WAVE: begin
                  if (ctl1[C1_DPX]) begin
                     next_out_lvl = pwm_level(next_cnt[15:8] < cmpp, ctl1[C1_OC]);
                  end else begin
                     next_out_lvl = pwm_level(next_cnt < cmpa, ctl1[C1_OC]);
                  end
               end
               default: next_out_lvl = out_lvl;
            endcase
         end
         default: next_out_lvl = out_lvl;
      endcase
      next_out_pin = next_out_lvl ^ ctl1[C1_POL];
   end

   // state registers
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ctl0 <= CTL_RESET;
         ctl1 <= CTL_RESET;
         cnt <= 16'h0000;
         cmpa <= 16'h0000;
         cmpp <= 8'h00;
         shadow <= 8'h00;
         rdata_o <= 8'h00;
         out_lvl <= 1'b0;
         out_pin_o <= 1'b0;
         irq_a_o <= 1'b0;
         irq_p_o <= 1'b0;
      end else begin
         ctl0 <= next_ctl0;
         ctl1 <= next_ctl1;
         cnt <= next_cnt;
         cmpa <= next_cmpa;
         cmpp <= next_cmpp;
         shadow <= next_shadow;
         rdata_o <= next_rdata;
         out_lvl <= next_out_lvl;
         out_pin_o <= next_out_pin;
         irq_a_o <= next_irq_a;
         irq_p_o <= next_irq_p;
      end
   end

   // checks
   a_run_clears_cnt: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == REG_CTL0 && wdata_i[C0_RUN] && !ctl0[C0_RUN]) |=> (cnt == 16'h0000))
      else $error("counter not cleared on run rise");

   a_cmpa_low_only: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == REG_CMPA_L) |=> (cmpa == $past(cmpa) && shadow == $past(wdata_i)))
      else $error("low byte write touched compare value");

   a_cmpa_pair_load: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == REG_CMPA_H) |=> (cmpa == {$past(wdata_i), $past(shadow)}))
      else $error("compare pair not loaded together");

   a_cnt_high_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == REG_CNT_H) |=> (rdata_o == $past(cnt[15:8]) && shadow == $past(cnt[7:0])))
      else $error("high read did not capture low byte");

   a_low_read_shadow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_i && (addr_i == REG_CNT_L || addr_i == REG_CMPA_L)) |=> (rdata_o == $past(shadow)))
      else $error("low read not from shadow");

   a_irq_a_match: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (count_en && cnt + 16'h0001 == cmpa) |=> irq_a_o)
      else $error("comparator A match without request");

   a_irq_p_match: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      irq_p_o |-> ($past(count_en) && $past(cnt[7:0]) == 8'hff && $past(cnt[15:8]) + 8'h01 == $past(cmpp)))
      else $error("comparator P request without match");

   a_cmp_drive_high: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_CMP && !run_rise && match_a && io == IO_HIGH) |=> (out_pin_o == !$past(ctl1[C1_POL])))
      else $error("pin not driven high on match");

   a_pause_holds: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (ctl0[C0_PAUSE] && !run_rise) |=> (cnt == $past(cnt)))
      else $error("counter moved while paused");

   // request pulses: P can never match on two ticks in a row, so a long P pulse is a fault
   a_irq_p_single: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      irq_p_o |=> !irq_p_o)
      else $error("comparator P request longer than one cycle");

   a_irq_a_cause: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      irq_a_o |-> ($past(count_en) && $past(cnt) + 16'h0001 == $past(cmpa)))
      else $error("comparator A request without match");

   // register port: idle read data, compare high read, direct byte and clock select
   a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !rd_i |=> (rdata_o == 8'h00))
      else $error("read data not zero outside a read");

   a_cmpa_high_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_i && !wr_i && addr_i == REG_CMPA_H) |=> (rdata_o == $past(cmpa[15:8]) && shadow == $past(cmpa[7:0])))
      else $error("compare high read did not capture low byte");

   a_cmpp_direct: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == REG_CMPP) |=> (cmpp == $past(wdata_i)))
      else $error("comparator P byte not written directly");

   a_sel_field: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == REG_CTL0) |=> (ctl0[C0_SEL_HI:C0_SEL_LO] == $past(wdata_i[C0_SEL_HI:C0_SEL_LO])))
      else $error("clock select field not loaded");

   // counter movement: hold without a tick, step by one, clear on the chosen match
   a_cnt_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (!count_en && !run_rise) |=> (cnt == $past(cnt)))
      else $error("counter moved without a tick");

   a_cnt_step: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (count_en && !run_rise && !match_a && !match_p) |=> (cnt == $past(cnt) + 16'h0001))
      else $error("counter did not step by one");

   a_clear_on_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (!run_rise && match_a && clear_on_a) |=> (cnt == 16'h0000))
      else $error("counter not cleared on comparator A");

   a_clear_on_p: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (!run_rise && match_p && !clear_on_a) |=> (cnt == 16'h0000))
      else $error("counter not cleared on comparator P");

   // pin actions in compare, pwm and timer modes
   a_cmp_drive_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_CMP && !run_rise && match_a && io == IO_LOW) |=> (out_pin_o == $past(ctl1[C1_POL])))
      else $error("pin not driven low on match");

   a_cmp_toggle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_CMP && !run_rise && match_a && io == IO_TOGGLE) |=> (out_lvl != $past(out_lvl)))
      else $error("pin not toggled on match");

   a_run_sets_level: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_CMP && run_rise) |=> (out_lvl == $past(ctl1[C1_OC])))
      else $error("run rise did not restore initial level");

   a_pwm_active: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_PWM && io == PWM_ACTIVE) |=> (out_pin_o == ($past(ctl1[C1_OC]) ^ $past(ctl1[C1_POL]))))
      else $error("pwm active state wrong");

   a_pwm_inactive: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_PWM && io == PWM_INACTIVE) |=> (out_pin_o == (!$past(ctl1[C1_OC]) ^ $past(ctl1[C1_POL]))))
      else $error("pwm inactive state wrong");

   a_pin_polarity: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      1'b1 |=> (out_pin_o == (out_lvl ^ $past(ctl1[C1_POL]))))
      else $error("pin level and polarity disagree");

   a_tmr_holds_level: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (mode == MODE_TMR) |=> (out_lvl == $past(out_lvl)))
      else $error("timer mode moved the pin level");

   c_match_a: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) irq_a_o);
   c_match_p: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) irq_p_o);
   c_pwm_edge: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      mode == MODE_PWM && $rose(out_pin_o));
   c_byte_read: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == REG_CNT_H) ##1 (rd_i && addr_i == REG_CNT_L));
   c_pair_write: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == REG_CMPA_L) ##1 (wr_i && addr_i == REG_CMPA_H));
endmodule

/* test/mpt_pin_partner.sv */
// far-side model of the timer clock pin: an external event source with a settable pace
// assumes one core clock; the source is synchronous to it and stands still while disabled
`timescale 1ns/1ps
module mpt_pin_partner (
   input wire logic core_clk_i,
   input wire logic en_i,
   input wire logic [3:0] half_i,
   output logic clock_pin_o
);
   int cnt = 0;

   // the pin only ever feeds the timer, so the timer side never drives it
   initial clock_pin_o = 1'h0;

   // toggle every half_i core cycles while enabled; no edges at all otherwise
   always @(posedge core_clk_i) begin
      if (en_i) begin
         cnt <= (cnt >= int'(half_i) - 1) ? 0 : cnt + 1;
         if (cnt >= int'(half_i) - 1) begin
            clock_pin_o <= ~clock_pin_o;
         end
      end
   end
endmodule

/* test/mpt_timer_tb.sv */
// self-checking bench of the compact timer: register model, clock selects, compare and pwm output
// assumes the timer package, the timer and the clock pin partner are compiled before it
`timescale 1ns/1ps
module mpt_timer_tb;
   import mpt_pkg::*;
   logic core_clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic wr_i = 1'h0;
   logic rd_i = 1'h0;
   logic fh_tick_i = 1'h0;
   logic fsub_tick_i = 1'h0;
   logic pin_en = 1'h0;
   logic [3:0] pin_half = 4'h3;
   logic clock_pin_i;
   logic [DATA_W-1:0] rdata_o;
   logic out_pin_o;
   logic irq_a_o;
   logic irq_p_o;
   int miscompares = 0;
   int tests_run = 0;
   int unsigned seed = 79093;
   int regs [8] = '{default: 0};
   int shadow_m = 0;
   int cyc = 0;
   int n;
   int per [8] = '{4, 1, 32, 128, 4, 4, 6, 2};
   logic [7:0] lo;
   logic [15:0] v1;
   logic [15:0] v2;
   logic p0;

   mpt_timer i_mpt_timer (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fh_tick_i(fh_tick_i), .fsub_tick_i(fsub_tick_i),
      .clock_pin_i(clock_pin_i), .out_pin_o(out_pin_o), .irq_a_o(irq_a_o), .irq_p_o(irq_p_o));
   mpt_pin_partner i_mpt_pin_partner (.core_clk_i(core_clk_i), .en_i(pin_en), .half_i(pin_half),
      .clock_pin_o(clock_pin_i));

   // core clock, high clock enable every 2 cycles, sub clock enable every 4
   always #25 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      fh_tick_i <= (cyc % 2 == 0);
      fsub_tick_i <= (cyc % 4 == 0);
   end

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic give_verdict();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one write cycle; the model keeps control, shadow and compare values
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_i <= 1'h1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'h0;
      case (a)
         REG_CTL0: regs[0] = d & 8'hf8;
         REG_CMPA_L: shadow_m = d;
         REG_CMPA_H: begin
            regs[5] = d;
            regs[4] = shadow_m;
         end
         REG_CTL1, REG_CMPP: regs[a] = d;
         default: ;
      endcase
   endtask

   // one read cycle, data taken in the cycle after; the live counter is unknown to the model
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      int e;
      e = (a == REG_CMPA_L || a == REG_CNT_L) ? shadow_m : (a == REG_CNT_H ? -1 : regs[a]);
      if (a == REG_CMPA_H) shadow_m = regs[4];
      if (a == REG_CNT_H) shadow_m = -1;
      @(posedge core_clk_i);
      rd_i <= 1'h1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'h0;
      #1 d = rdata_o;
      if (e >= 0) chk({8'h00, d}, 16'(e));
   endtask

   // cycles until the next request pulse, bounded
   task automatic wait_irq(input logic use_p, output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk_i);
         #1 cnt++;
      end while ((use_p ? irq_p_o : irq_a_o) !== 1'h1 && cnt < 4000);
      if (cnt >= 4000) begin
         miscompares++;
         give_verdict();
      end
   endtask

   initial begin
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'h0;
      // reset values, read-only counter and the unused offset
      for (int a = 0; a < 8; a++) rd(a[2:0], lo);
      wr(REG_CTL0, 8'hff);
      rd(REG_CTL0, lo);
      wr(REG_CTL0, 8'h00);
      wr(REG_CNT_H, 8'h55);
      wr(3'h7, 8'haa);
      rd(3'h7, lo);
      rd(REG_CNT_H, lo);
      chk({8'h00, lo}, 16'h0000);
      // compare A pair: low write stays in the shadow until the high write
      lo = 8'(rnd()) | 8'h01;
      v2[15:8] = 8'(rnd());
      wr(REG_CMPA_L, lo); // low byte first, then high
      wr(REG_CMPA_H, v2[15:8]);
      wr(REG_CMPA_L, ~lo);
      rd(REG_CMPA_L, v1[7:0]);
      rd(REG_CMPA_H, v1[15:8]);
      rd(REG_CMPA_L, v1[7:0]);
      chk(v1, {v2[15:8], lo});
      // every counter clock select; compare A clears the count and toggles the pin
      v1 = 16'(rnd() % 8 + 3);
      wr(REG_CMPA_L, v1[7:0]);
      wr(REG_CMPA_H, 8'h00);
      wr(REG_CTL1, 8'h31);
      for (int s = 0; s < 8; s++) begin
         pin_en <= (s >= 6);
         pin_half <= (s == 6) ? 4'h3 : 4'h1;
         wr(REG_CTL0, {1'h0, 3'(s), 4'h8});
         wait_irq(1'h0, n);
         wait_irq(1'h0, n);
         chk(16'(n), 16'(per[s] * v1));
         repeat (2) @(posedge core_clk_i);
         #1 p0 = out_pin_o;
         wait_irq(1'h0, n);
         repeat (2) @(posedge core_clk_i);
         #1 chk({15'h0, out_pin_o}, {15'h0, ~p0});
         wr(REG_CTL0, 8'h00);
      end
      // drive low or high from the opposite initial level, with and without inversion
      wr(REG_CMPA_L, 8'h00);
      wr(REG_CMPA_H, 8'h01);
      for (int k = 0; k < 4; k++) begin
         wr(REG_CTL1, {2'h0, k[0] ? IO_HIGH : IO_LOW, ~k[0], k[1], 2'h1});
         wr(REG_CTL0, 8'h18);
         repeat (4) @(posedge core_clk_i);
         #1 chk({15'h0, out_pin_o}, {15'h0, ~k[0] ^ k[1]});
         wait_irq(1'h0, n);
         repeat (2) @(posedge core_clk_i);
         #1 chk({15'h0, out_pin_o}, {15'h0, k[0] ^ k[1]});
         wr(REG_CTL0, 8'h00);
      end
      // comparator P on the upper counter byte sets the period, A fires once per period
      wr(REG_CMPA_L, lo);
      wr(REG_CMPA_H, 8'h00);
      wr(REG_CMPP, 8'h01);
      wr(REG_CTL1, 8'h00);
      wr(REG_CTL0, 8'h18);
      wait_irq(1'h1, n);
      wait_irq(1'h1, n);
      chk(16'(n), 16'h0100);
      wait_irq(1'h0, n);
      wait_irq(1'h0, n);
      chk(16'(n), 16'h0100);
      // pwm wave: period from P, duty from A, active high then inverted
      for (int k = 0; k < 2; k++) begin
         wr(REG_CTL0, 8'h00);
         wr(REG_CTL1, {MODE_PWM, PWM_WAVE, 1'h1, k[0], 2'h0});
         wr(REG_CTL0, 8'h18);
         wait_irq(1'h1, n);
         n = 0;
         repeat (256) begin
            @(posedge core_clk_i);
            #1 n += (out_pin_o === 1'h1);
         end
         chk(16'(n), k ? 16'(256 - lo) : 16'(lo));
      end
      // pause freezes the count, a rising run bit clears it
      wr(REG_CTL0, 8'h00);
      wr(REG_CTL1, 8'hc0);
      wr(REG_CTL0, 8'h18);
      repeat (20) @(posedge core_clk_i);
      wr(REG_CTL0, 8'h98);
      rd(REG_CNT_H, v1[15:8]);
      rd(REG_CNT_L, v1[7:0]);
      repeat (5) @(posedge core_clk_i);
      rd(REG_CNT_H, v2[15:8]);
      rd(REG_CNT_L, v2[7:0]);
      chk(v2, v1);
      chk({15'h0, v1 != 16'h0000}, 16'h0001);
      wr(REG_CTL0, 8'h90);
      wr(REG_CTL0, 8'h98);
      rd(REG_CNT_H, v1[15:8]);
      rd(REG_CNT_L, v1[7:0]);
      chk(v1, 16'h0000);
      give_verdict();
   end
endmodule
